/* File: src/lac_top.sv */
// Control and result registers of the integrating light converter
`timescale 1ns/1ps
`include "lac_defs.svh"

module lac_top
  import lac_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Register port from the serial slave framing
  input  wire lac_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  // Device address match
  input  wire logic         address_select_pin,
  input  wire logic [6:0]   slave_addr,
  output logic              addr_match,
  // Converter core
  input  wire logic         osc_tick,
  input  wire logic         light_sample,
  output logic              core_reset,
  output logic              power_down,
  output logic              osc_half_speed,
  output logic [17:0]       range_const
);

  lac_state_t st_r;
  lac_state_t st_nxt;

  logic [16:0] cyc_target;
  logic        conv_on;
  logic        run;
  logic        sync_wr;
  logic        tick;
  logic [15:0] acc_step;
  logic [15:0] signed_res;
  logic [1:0]  width_sel;

  // Field views of the setup registers, write strobes and next values of the counters
  logic [1:0]  diode_sel;
  logic [1:0]  range_sel;
  logic        wr_op;
  logic        wr_range;
  logic        int_done;
  logic [16:0] cnt_inc;
  logic [15:0] acc_inc;
  logic [15:0] tally_inc;
  logic [15:0] res_src;
  logic [7:0]  rd_nxt;

  assign width_sel = st_r.op_setup[`LAC_WIDTH_HI:`LAC_WIDTH_LO];
  assign diode_sel = st_r.op_setup[`LAC_DIODE_HI:`LAC_DIODE_LO];
  assign range_sel = st_r.range_setup[`LAC_RANGE_HI:`LAC_RANGE_LO];
  assign sync_wr   = reg_req.wr & reg_req.addr[`LAC_SYNC_BIT];
  // Sync writes carry an address byte that must not hit a register
  assign wr_op     = reg_req.wr & ~sync_wr &
    (reg_req.addr == `LAC_OFS_OP_SETUP);
  assign wr_range  = reg_req.wr & ~sync_wr &
    (reg_req.addr == `LAC_OFS_RANGE_SETUP);

  // Next values of the integration counters, one oscillator cycle on
  assign cnt_inc   = st_r.int_cnt + 17'h00001;
  assign acc_inc   = st_r.acc + acc_step;
  assign tally_inc = st_r.run_tally + 16'h0001;
  // Last cycle of an internally timed conversion
  assign int_done  = (cnt_inc >= cyc_target);
  // A tick in the closing cycle still belongs to this result
  assign res_src   = tick ? acc_inc : st_r.acc;

  // ranges 0 and 1 halve the oscillator
  assign osc_half_speed = st_r.osc_half;

  // core held in reset while enable clear
  assign core_reset = ~st_r.op_setup[`LAC_BIT_ENABLE];
  // power-down request straight to the core
  assign power_down = st_r.op_setup[`LAC_BIT_PWRDN];
  // only the light-count diode code converts
  assign conv_on = ~core_reset & ~power_down &
    (diode_sel == `LAC_DIODE_LIGHT);
  assign run  = conv_on & (st_r.phase != LAC_IDLE);
  assign tick = osc_tick & run;
  assign acc_step = light_sample ? 16'h0001 : 16'h0000;
  assign reg_rdata  = st_r.rdata;
  assign addr_match = st_r.dev_match;

  // cycles per conversion from width field
  always_comb
  begin
    case (width_sel)
      // The full count needs 17 bits so the compare never wraps
      2'h0:
      begin
        cyc_target = `LAC_CYC_W0;
      end
      2'h1:
      begin
        cyc_target = `LAC_CYC_W1;
      end
      2'h2:
      begin
        cyc_target = `LAC_CYC_W2;
      end
      default:
      begin
        cyc_target = `LAC_CYC_W3;
      end
    endcase
  end

  always_comb
  begin
    // Constant follows the stored step, not a pending write
    case (range_sel)
      2'h0:
      begin
        range_const = `LAC_RANGE_K0;
      end
      2'h1:
      begin
        range_const = `LAC_RANGE_K1;
      end
      2'h2:
      begin
        range_const = `LAC_RANGE_K2;
      end
      default:
      begin
        range_const = `LAC_RANGE_K3;
      end
    endcase
  end

  // clip the count to a signed n-1 bit result
  always_comb
  begin
    case (width_sel)
      // Overflow wraps rather than saturates
      2'h0:
      begin
        signed_res = {1'b0, res_src[14:0]};
      end
      2'h1:
      begin
        signed_res = {5'h00, res_src[10:0]};
      end
      2'h2:
      begin
        signed_res = {9'h000, res_src[6:0]};
      end
      default:
      begin
        signed_res = {13'h0000, res_src[2:0]};
      end
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.osc_half = ~st_r.range_setup[`LAC_RANGE_HI];
    // Pin level passes two flops before use
    st_nxt.sync1_a0 = address_select_pin;
    st_nxt.sync2_a0 = st_r.sync1_a0;
    // fixed upper six bits plus pin level
    st_nxt.dev_match = (slave_addr == {`LAC_ADDR_UPPER, st_r.sync2_a0});

    if (wr_op)
    begin
      st_nxt.op_setup = reg_req.wdata;
    end
    // only the range step bits stored
    if (wr_range)
    begin
      st_nxt.range_setup = reg_req.wdata & `LAC_RANGE_MASK;
    end
    // result offsets have no write path

    // internal timing counts a fixed number of cycles
    if (!st_r.op_setup[`LAC_BIT_EXT_TIMING])
    begin
      st_nxt.phase = conv_on ? LAC_ARRAY1 : LAC_IDLE;
      if (tick)
      begin
        st_nxt.int_cnt = cnt_inc;
        st_nxt.acc = acc_inc;
        st_nxt.run_tally = tally_inc;
        if (int_done)
        begin
          st_nxt.light = signed_res;
          st_nxt.tally = tally_inc;
          st_nxt.int_cnt = 17'h00000;
          st_nxt.acc = 16'h0000;
          st_nxt.run_tally = 16'h0000;
        end
      end
    end
    else
    begin
      if (tick)
      begin
        st_nxt.acc = acc_inc;
        st_nxt.run_tally = tally_inc;
      end
      // sync write in array 2 ends and restarts integration; in idle it starts one, in array 1 it only switches array
      // host delimits with three sync writes
      if (sync_wr && conv_on)
      begin
        case (st_r.phase)
          LAC_IDLE:
          begin
            st_nxt.phase = LAC_ARRAY1;
            st_nxt.acc = 16'h0000;
            st_nxt.run_tally = 16'h0000;
          end
          LAC_ARRAY1:
          begin
            st_nxt.phase = LAC_ARRAY2;
          end
          LAC_ARRAY2:
          begin
            st_nxt.phase = LAC_ARRAY1;
            st_nxt.light = signed_res;
            // tally paired with this count
            // A tick in the closing cycle is counted here too
            st_nxt.tally = tick ? tally_inc : st_r.run_tally;
            st_nxt.acc = 16'h0000;
            st_nxt.run_tally = 16'h0000;
          end
          default:
          begin
            st_nxt.phase = LAC_IDLE;
          end
        endcase
      end
      else if (!conv_on)
      begin
        // Leaving light mode forgets the array sequence
        st_nxt.phase = LAC_IDLE;
      end
    end

    // held core drops its partial integration
    if (core_reset)
    begin
      st_nxt.int_cnt = 17'h00000;
      st_nxt.acc = 16'h0000;
      st_nxt.run_tally = 16'h0000;
    end

    st_nxt.rdata = rd_nxt;
  end

  // Read data is registered, so it answers the address of the last cycle
  always_comb
  begin
    case (reg_req.addr)
      `LAC_OFS_OP_SETUP:
      begin
        rd_nxt = st_r.op_setup;
      end
      `LAC_OFS_RANGE_SETUP:
      begin
        rd_nxt = st_r.range_setup;
      end
      `LAC_OFS_LIGHT_LO:
      begin
        rd_nxt = st_r.light[7:0];
      end
      `LAC_OFS_LIGHT_HI:
      begin
        rd_nxt = st_r.light[15:8];
      end
      `LAC_OFS_TALLY_LO:
      begin
        rd_nxt = st_r.tally[7:0];
      end
      `LAC_OFS_TALLY_HI:
      begin
        rd_nxt = st_r.tally[15:8];
      end
      // Unmapped and write-only offsets read back as zero
      default:
      begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r.op_setup    <= `LAC_OP_RESET;
      st_r.range_setup <= `LAC_RANGE_RESET;
      st_r.light       <= 16'h0000;
      st_r.tally       <= 16'h0000;
      st_r.run_tally   <= 16'h0000;
      st_r.int_cnt     <= 17'h00000;
      st_r.osc_half    <= 1'b1;
      st_r.phase       <= LAC_IDLE;
      st_r.acc         <= 16'h0000;
      st_r.rdata       <= 8'h00;
      st_r.sync1_a0    <= 1'b0;
      st_r.sync2_a0    <= 1'b0;
      st_r.dev_match   <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

endmodule : lac_top

/* File: common/lac_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LAC_DEFS_SVH
`define LAC_DEFS_SVH
`define LAC_OFS_OP_SETUP     8'h00
`define LAC_OFS_RANGE_SETUP  8'h01
`define LAC_OFS_LIGHT_LO     8'h04
`define LAC_OFS_LIGHT_HI     8'h05
`define LAC_OFS_TALLY_LO     8'h06
`define LAC_OFS_TALLY_HI     8'h07
`define LAC_SYNC_BIT         7
`define LAC_BIT_ENABLE       7
`define LAC_BIT_PWRDN        6
`define LAC_BIT_EXT_TIMING   5
`define LAC_DIODE_HI         3
`define LAC_DIODE_LO         2
`define LAC_WIDTH_HI         1
`define LAC_WIDTH_LO         0
`define LAC_RANGE_HI         3
`define LAC_RANGE_LO         2
`define LAC_RANGE_MASK       8'h0c
`define LAC_OP_RESET         8'h00
`define LAC_RANGE_RESET      8'h00
`define LAC_DIODE_LIGHT      2'h2
`define LAC_ADDR_UPPER       6'h22
`define LAC_CYC_W0           17'h10000
`define LAC_CYC_W1           17'h01000
`define LAC_CYC_W2           17'h00100
`define LAC_CYC_W3           17'h00010
`define LAC_RANGE_K0         18'h007d0
`define LAC_RANGE_K1         18'h01f40
`define LAC_RANGE_K2         18'h07d00
`define LAC_RANGE_K3         18'h1f400
`endif

/* File: common/lac_pkg.sv */
// Types for the light converter control block
package lac_pkg;
  typedef enum logic [2:0] {
    LAC_IDLE   = 3'b001,
    LAC_ARRAY1 = 3'b010,
    LAC_ARRAY2 = 3'b100
  } lac_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } lac_reg_req_t;

  typedef struct packed {
    logic [7:0]  op_setup;
    logic [7:0]  range_setup;
    logic [15:0] light;
    logic [15:0] tally;
    logic [15:0] run_tally;
    logic [16:0] int_cnt;
    logic        osc_half;
    lac_phase_t  phase;
    logic [15:0] acc;
    logic [7:0]  rdata;
    logic        sync1_a0;
    logic        sync2_a0;
    logic        dev_match;
  } lac_state_t;
endpackage : lac_pkg

/* File: verification/lac_props.sv */
// Port-level assertions for the light converter control block
`timescale 1ns/1ps
module lac_props
  import lac_pkg::*;
(
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         sys_rst,
  // Register port
  input wire lac_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  // Address match
  input wire logic         address_select_pin,
  input wire logic [6:0]   slave_addr,
  input wire logic         addr_match,
  // Converter core
  input wire logic         osc_tick,
  input wire logic         light_sample,
  input wire logic         core_reset,
  input wire logic         power_down,
  input wire logic         osc_half_speed,
  input wire logic [17:0]  range_const
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire wr_op  = reg_req.wr && reg_req.addr == 8'h00;
  wire wr_rng = reg_req.wr && reg_req.addr == 8'h01;
  a_core_enable: assert property (wr_op |=>
    core_reset == !$past(reg_req.wdata[7])) else $error("core reset wrong");
  a_pd_follow: assert property (wr_op |=>
    power_down == $past(reg_req.wdata[6])) else $error("power down wrong");
  a_reset_state: assert property ($fell(sys_rst) |->
    core_reset && !power_down && osc_half_speed && reg_rdata == 8'h00)
    else $error("reset state wrong");
  a_op_readback: assert property (
    wr_op ##1 (reg_req.addr == 8'h00 && !reg_req.wr) |=>
    reg_rdata == $past(reg_req.wdata, 2)) else $error("op readback wrong");
  a_range_mask: assert property (reg_req.addr == 8'h01 |=>
    (reg_rdata & 8'hf3) == 8'h00) else $error("range bits leak");
  a_range_const: assert property (wr_rng |=>
    range_const == (18'd2000 << {$past(reg_req.wdata[3:2]), 1'b0}))
    else $error("range constant wrong");
  a_half_speed: assert property (wr_rng |=> ##2
    osc_half_speed == !$past(reg_req.wdata[3], 3)) else $error("osc speed");
  a_unmapped_zero: assert property (
    reg_req.addr inside {8'h02, 8'h03, [8'h08:8'h7f]} |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_addr_miss: assert property (slave_addr[6:1] != 6'h22 |=>
    !addr_match) else $error("false address match");
endmodule : lac_props
bind lac_top lac_props lac_props_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .slave_addr(slave_addr),
  .address_select_pin(address_select_pin), .addr_match(addr_match),
  .osc_tick(osc_tick), .light_sample(light_sample), .core_reset(core_reset),
  .power_down(power_down), .osc_half_speed(osc_half_speed),
  .range_const(range_const));

/* File: verification/lac_host.sv */
// Host model issuing register reads, writes and sync writes
`timescale 1ns/1ps
module lac_host
  import lac_pkg::*;
(
  // Clock
  input wire logic         core_clk,
  // Register port toward the block
  output lac_reg_req_t     reg_req,
  input wire logic [7:0]   reg_rdata
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req <= '{a, d, 1'b1};
    @(negedge core_clk);
    // Released data byte no longer shows the written value
    reg_req <= '{a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_req <= '{a, reg_req.wdata, 1'b0};
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  task automatic sync_pulse;
    wr(8'h80, 8'h00);
  endtask : sync_pulse
endmodule : lac_host

/* File: verification/test_lac_top.sv */
// Self-checking bench for the light converter control block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_lac_top
  import lac_pkg::*;
;
  logic         core_clk = 1'b0, sys_rst = 1'b1, address_select_pin = 1'b0;
  logic         osc_tick = 1'b0, light_sample = 1'b0;
  logic [6:0]   slave_addr = '0;
  lac_reg_req_t reg_req;
  logic [7:0]   reg_rdata, v, w;
  logic [15:0]  r;
  logic         addr_match, core_reset, power_down, osc_half_speed;
  logic [17:0]  range_const;
  int           n_errors = 0, checked = 0, k, k2, t1, t2;
  logic [7:0]   ofs [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07};
  always #25 core_clk = ~core_clk;
  lac_top lac_top_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .slave_addr(slave_addr),
    .address_select_pin(address_select_pin), .addr_match(addr_match),
    .osc_tick(osc_tick), .light_sample(light_sample), .core_reset(core_reset),
    .power_down(power_down), .osc_half_speed(osc_half_speed),
    .range_const(range_const));
  lac_host lac_host_inst (.core_clk(core_clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata));
  function automatic logic [17:0] rconst(input logic [1:0] c);
    return 18'd2000 << {c, 1'b0};
  endfunction : rconst
  task automatic ticks(input int n, input int m);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      osc_tick = 1'b1;
      light_sample = (i < m);
      @(negedge core_clk);
      osc_tick = 1'b0;
      light_sample = ~light_sample;
    end
  endtask : ticks
  task automatic rd16(input logic [7:0] a, output logic [15:0] q);
    lac_host_inst.rd(a, q[7:0]);
    lac_host_inst.rd(a + 8'h01, q[15:8]);
  endtask : rd16
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Whole run needs a few hundred cycles
  initial
  begin
    #(50 * 20000);
    n_errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h814745be));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    foreach (ofs[i])
    begin
      lac_host_inst.rd(ofs[i], v);
      `CHK(v, 8'h00)
    end
    `CHK({core_reset, power_down}, 2'b10)
    for (int c = 0; c < 4; c++)
    begin
      v = ($urandom & 8'hf3) | 8'(c << 2);
      lac_host_inst.wr(8'h01, v);
      `CHK(range_const, rconst(c[1:0]))
      lac_host_inst.rd(8'h01, v);
      `CHK(v, {4'h0, c[1:0], 2'b00})
      `CHK(osc_half_speed, ~c[1])
      w = $urandom & 8'hef;
      lac_host_inst.wr(8'h00, w);
      `CHK({core_reset, power_down}, {~w[7], w[6]})
      lac_host_inst.rd(8'h00, v);
      `CHK(v, w)
    end
    lac_host_inst.wr(8'h02, 8'h5a);
    lac_host_inst.rd(8'h02, v);
    `CHK(v, 8'h00)
    lac_host_inst.rd(8'h00, v);
    `CHK(v, w)
    $display("register test done");
    lac_host_inst.wr(8'h00, 8'h00);
    lac_host_inst.wr(8'h00, 8'h8b);
    k = $urandom_range(6, 1);
    ticks(15, k);
    rd16(8'h04, r);
    `CHK(r, 16'h0000)
    ticks(1, 1);
    rd16(8'h04, r);
    `CHK(r, 16'(k + 1))
    foreach (ofs[d])
    begin
      if (d < 4 && d != 2)
      begin
        lac_host_inst.wr(8'h00, 8'h83 | 8'(d << 2));
        ticks(16, 3);
        rd16(8'h04, r);
        `CHK(r, 16'(k + 1))
      end
    end
    $display("internal test done");
    lac_host_inst.wr(8'h00, 8'ha8);
    t1 = $urandom_range(20, 2);
    t2 = $urandom_range(20, 2);
    k = $urandom_range(t1, 0);
    k2 = $urandom_range(t2, 0);
    lac_host_inst.sync_pulse();
    ticks(t1, k);
    lac_host_inst.sync_pulse();
    ticks(t2, k2);
    lac_host_inst.sync_pulse();
    rd16(8'h04, r);
    `CHK(r, 16'(k + k2))
    rd16(8'h06, r);
    `CHK(r, 16'(t1 + t2))
    for (int a = 4; a < 8; a++)
      lac_host_inst.wr(8'(a), 8'($urandom));
    rd16(8'h06, r);
    `CHK(r, 16'(t1 + t2))
    $display("external test done");
    repeat (8)
    begin
      @(negedge core_clk);
      slave_addr = $urandom_range(1, 0) ? {6'h22, 1'($urandom)} : 7'($urandom);
      address_select_pin = 1'($urandom);
      repeat (4) @(negedge core_clk);
      `CHK(addr_match, slave_addr == {6'h22, address_select_pin})
    end
    $display("address test done");
    give_verdict();
  end
endmodule : test_lac_top
